// ---- core/eipu_top.sv ----
// external interrupt pin unit: request latch, sensitivity, masks, wake
// assumes a classic wishbone master, one clock, pin pulled up outside
`timescale 1ns/1ps
module eipu_top (
  input  logic                  clk,          // 10 MHz system clock
  input  logic                  rst_n,        // async reset, active low
  input  eipu_pkg::eipu_wb_req_t wbReq,       // wishbone request
  output eipu_pkg::eipu_wb_rsp_t wbRsp,       // wishbone answer
  input  logic                  extIntPin_n,  // interrupt pin, active low
  input  logic                  vectorFetch,  // cpu fetches our vector
  input  logic                  cpuIntMask,   // global mask in condition codes
  output logic                  cpuIrqReq,    // to priority logic
  output logic                  wakeReq,      // leaves wait or stop
  output logic                  pinLevel,     // for branch on pin level
  output logic                  pinIsGpio,    // pin left to port functions
  output logic                  irq           // event interrupt level
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic                 pinSync;
  logic                 pinPrev_q;
  logic                 reqLatch_q;
  logic                 reqLatch_d;
  logic                 localMask_q;
  eipu_pkg::eipu_sense_t sense_q;
  logic                 pinEnable_q;
  logic                 ack_q;
  logic [31:0]          rdat_q;
  logic                 busReq;
  logic                 wrTake;
  logic                 wrLane0;
  logic [5:0]           regIdx;
  logic                 fallEdge;
  logic                 levelActive;
  logic                 swAck;
  logic                 anyAck;
  logic                 request;
  logic                 levelMode;
  logic [eipu_pkg::EV_W-1:0] evSet;
  logic [eipu_pkg::EV_W-1:0] evStatus;
  logic [eipu_pkg::EV_W-1:0] evMask;
  logic                 evClrWr;
  logic                 evMskWr;
  logic                 ctlWrite;
  logic                 cfgWrite;
  logic [31:0]          rdWord;

  // ************************************************************
  // helpers
  // ************************************************************
  // word index from a byte address
  function automatic logic [5:0] word_idx(
    input logic [eipu_pkg::ADR_W-1:0] a
  );
    word_idx = a[7:2];
  endfunction

  // place a narrow field in the low bits of a bus word
  function automatic logic [31:0] low_word(
    input logic [3:0] v
  );
    low_word = {28'h000_0000, v};
  endfunction

  // write strobe of one register word; byte lane 0 holds every field
  function automatic logic wr_hit(
    input logic       take,
    input logic [5:0] idx,
    input logic [5:0] want
  );
    wr_hit = take & (idx == want);
  endfunction

  // ************************************************************
  // pin synchroniser
  // ************************************************************
  eipu_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (extIntPin_n),
    .dout  (pinSync)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pinPrev_q <= 1'b1;
    else        pinPrev_q <= pinSync;
  end

  // level seen by branch instructions, whatever the pin role
  assign pinLevel  = pinSync;
  assign pinIsGpio = ~pinEnable_q;

  // ************************************************************
  // wishbone slave
  // ************************************************************
  // one wait state: ack one cycle after the request, write lands on
  // the edge where the master sees ack, so a held request is taken once
  assign busReq  = wbReq.cyc & wbReq.stb;
  assign wrTake  = busReq & ack_q & wbReq.we;
  assign wrLane0 = wrTake & wbReq.sel[0];
  assign regIdx  = word_idx(wbReq.adr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ack_q <= 1'b0;
    else        ack_q <= busReq & ~ack_q;
  end

  // word of the addressed register, sampled when a read is taken
  always_comb begin
    rdWord = eipu_pkg::DAT_ZERO;
    case (regIdx)
      eipu_pkg::IDX_STATCTRL: begin
        // acknowledge bit is write-only and reads as zero
        rdWord = low_word({sense_q == eipu_pkg::SENSE_EDGE_LEVEL,
                           localMask_q, 1'b0, request});
      end
      eipu_pkg::IDX_CONFIG: begin
        rdWord = low_word({3'b000, pinEnable_q});
      end
      eipu_pkg::IDX_EVSTS: begin
        rdWord = low_word({2'b00, evStatus});
      end
      eipu_pkg::IDX_EVMASK: begin
        rdWord = low_word({2'b00, evMask});
      end
      eipu_pkg::IDX_PINLVL: begin
        rdWord = low_word({3'b000, pinSync});
      end
      default: begin
        // unmapped words answer with ack and zero
        rdWord = eipu_pkg::DAT_ZERO;
      end
    endcase
  end

  // read data captured at the request, steady while ack is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdat_q <= eipu_pkg::DAT_ZERO;
    end else if (busReq & ~ack_q & ~wbReq.we) begin
      rdat_q <= rdWord;
    end
  end

  assign wbRsp.ack = ack_q;
  assign wbRsp.dat = rdat_q;

  // ************************************************************
  // write decode
  // ************************************************************
  assign ctlWrite = wr_hit(wrLane0, regIdx, eipu_pkg::IDX_STATCTRL);
  assign cfgWrite = wr_hit(wrLane0, regIdx, eipu_pkg::IDX_CONFIG);

  // ************************************************************
  // control bits
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      localMask_q <= eipu_pkg::RST_MASK;
    end else if (ctlWrite) begin
      localMask_q <= wbReq.dat[eipu_pkg::BIT_MASK];
    end
  end

  // sensitivity leaves reset as edge only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_q <= eipu_pkg::SENSE_EDGE;
    end else if (ctlWrite) begin
      if (wbReq.dat[eipu_pkg::BIT_MODE])
        sense_q <= eipu_pkg::SENSE_EDGE_LEVEL;
      else
        sense_q <= eipu_pkg::SENSE_EDGE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinEnable_q <= eipu_pkg::RST_PINEN;
    end else if (cfgWrite) begin
      pinEnable_q <= wbReq.dat[eipu_pkg::BIT_PINEN];
    end
  end

  // ************************************************************
  // request latch
  // ************************************************************
  assign levelMode = (sense_q == eipu_pkg::SENSE_EDGE_LEVEL);

  // no edge or level counts while the pin serves its port role
  assign fallEdge    = pinEnable_q & pinPrev_q & ~pinSync;
  assign levelActive = pinEnable_q & levelMode & ~pinSync;

  assign swAck  = ctlWrite & wbReq.dat[eipu_pkg::BIT_ACK];
  assign anyAck = swAck | vectorFetch;

  // an edge in the acknowledge cycle still latches, so none is lost
  always_comb begin
    reqLatch_d = reqLatch_q;
    if (fallEdge)
      reqLatch_d = 1'b1;
    else if (anyAck)
      reqLatch_d = 1'b0;
    else if (!pinEnable_q)
      reqLatch_d = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reqLatch_q <= 1'b0;
    else        reqLatch_q <= reqLatch_d;
  end

  // in level mode the low pin keeps the request up after an
  // acknowledge; it drops only once both have happened, any order
  // the latch is gated by the enable too: it clears one edge after the
  // pin is handed back, and that edge must not show a request
  assign request = (reqLatch_q & pinEnable_q) | levelActive;

  // ************************************************************
  // outputs to the cpu
  // ************************************************************
  // level mode users should set the local mask in the service routine,
  // else the request re-enters while the pin stays low
  assign cpuIrqReq = request & ~localMask_q & ~cpuIntMask;

  // purely combinational so it works with the cpu clocks stopped
  assign wakeReq   = request & ~localMask_q;

  // ************************************************************
  // event status and interrupt
  // ************************************************************
  assign evSet[eipu_pkg::EV_LATCHSET] = fallEdge & ~reqLatch_q;
  assign evSet[eipu_pkg::EV_CLEARED]  = anyAck & reqLatch_q & ~fallEdge;
  assign evClrWr = wr_hit(wrLane0, regIdx, eipu_pkg::IDX_EVSTS);
  assign evMskWr = wr_hit(wrLane0, regIdx, eipu_pkg::IDX_EVMASK);

  eipu_evbank #(
    .W (eipu_pkg::EV_W)
  ) u_evbank (
    .clk     (clk),
    .rst_n   (rst_n),
    .evSet   (evSet),
    .clrWr   (evClrWr),
    .clrBits (wbReq.dat[eipu_pkg::EV_W-1:0]),
    .mskWr   (evMskWr),
    .mskBits (wbReq.dat[eipu_pkg::EV_W-1:0]),
    .status  (evStatus),
    .mask    (evMask),
    .irq     (irq)
  );

endmodule // eipu_top

// ---- core/eipu_pkg.sv ----
// constants, field layouts and bus carriers of the external interrupt unit
// assumes a 10 MHz system clock and a classic wishbone master on 32 bits
package eipu_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam int        ADR_W        = 8;
  localparam logic [5:0] IDX_STATCTRL = 6'h00; // 0x0000
  localparam logic [5:0] IDX_CONFIG   = 6'h01; // 0x0004
  localparam logic [5:0] IDX_EVSTS    = 6'h02; // 0x0008
  localparam logic [5:0] IDX_EVMASK   = 6'h03; // 0x000C
  localparam logic [5:0] IDX_PINLVL   = 6'h04; // 0x0010

  // ************************************************************
  // fields
  // ************************************************************
  localparam int BIT_PENDING = 0; // ext_int_status_control
  localparam int BIT_ACK     = 1;
  localparam int BIT_MASK    = 2;
  localparam int BIT_MODE    = 3;
  localparam int BIT_PINEN   = 0; // second_configuration_word
  localparam int BIT_PINLVL  = 0;

  // sticky event bits
  localparam int EV_W        = 2;
  localparam int EV_LATCHSET = 0;
  localparam int EV_CLEARED  = 1;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic RST_MASK  = 1'b0;
  localparam logic RST_MODE  = 1'b0;
  localparam logic RST_PINEN = 1'b0;
  localparam logic [31:0] DAT_ZERO = 32'h0000_0000;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [3:0]       sel;
    logic [ADR_W-1:0] adr;
    logic [31:0]      dat;
  } eipu_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } eipu_wb_rsp_t;

  typedef enum logic {SENSE_EDGE, SENSE_EDGE_LEVEL} eipu_sense_t;

endpackage

// ---- core/eipu_sync.sv ----
// two flip-flop synchroniser for the interrupt pin
// assumes the pin idles high (internal pull-up outside)
`timescale 1ns/1ps
module eipu_sync (
  input  logic clk,   // system clock
  input  logic rst_n, // async reset, active low
  input  logic din,   // asynchronous pin level
  output logic dout   // synchronised level
);
  logic meta_q;
  logic sync_q;

  // resets high so an idle pin gives no edge on release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule // eipu_sync

// ---- core/eipu_evbank.sv ----
// sticky event status, mask and level interrupt output
// assumes single-cycle event pulses and write strobes on clk
`timescale 1ns/1ps
module eipu_evbank #(
  parameter int W = 2 // number of event bits
) (
  input  logic         clk,      // system clock
  input  logic         rst_n,    // async reset, active low
  input  logic [W-1:0] evSet,    // event pulses
  input  logic         clrWr,    // write-one-to-clear strobe
  input  logic [W-1:0] clrBits,  // bits to clear
  input  logic         mskWr,    // mask write strobe
  input  logic [W-1:0] mskBits,  // new mask value
  output logic [W-1:0] status,   // sticky bits
  output logic [W-1:0] mask,     // mask, 1 enables
  output logic         irq       // level interrupt
);
  logic [W-1:0] sts_q;
  logic [W-1:0] msk_q;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sts_q <= '0;
    else        sts_q <= (sts_q & ~(clrWr ? clrBits : '0)) | evSet;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)     msk_q <= '0;
    else if (mskWr) msk_q <= mskBits;
  end

  assign status = sts_q;
  assign mask   = msk_q;
  assign irq    = |(sts_q & msk_q);
endmodule // eipu_evbank

// ---- dv/eipu_top_props.sv ----
// checker on the pins of the external interrupt unit
// assumes a bind into eipu_top; mask and mode are shadowed from bus writes
`timescale 1ns/1ps
module eipu_top_props (
  input logic                   clk,         // clock
  input logic                   rst_n,       // reset
  input eipu_pkg::eipu_wb_req_t wbReq,       // bus request
  input eipu_pkg::eipu_wb_rsp_t wbRsp,       // bus answer
  input logic                   extIntPin_n, // pin
  input logic                   vectorFetch, // vector fetch
  input logic                   cpuIntMask,  // global mask
  input logic                   cpuIrqReq,   // request
  input logic                   wakeReq,     // wake
  input logic                   pinLevel,    // pin level
  input logic                   pinIsGpio,   // pin off
  input logic                   irq          // event irq
);
  logic ctlWr, clr, mskQ, modeQ;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign ctlWr = wbReq.cyc & wbReq.stb & wbReq.we & wbRsp.ack
    & wbReq.sel[0] & (wbReq.adr[7:2] == eipu_pkg::IDX_STATCTRL);
  assign clr = vectorFetch | (ctlWr & wbReq.dat[eipu_pkg::BIT_ACK]);
  // shadows move where the master sees ack, so ack cycles are skipped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mskQ <= eipu_pkg::RST_MASK;
      modeQ <= eipu_pkg::RST_MODE;
    end else if (ctlWr) begin
      mskQ <= wbReq.dat[eipu_pkg::BIT_MASK];
      modeQ <= wbReq.dat[eipu_pkg::BIT_MODE];
    end
  end
  property p_off; pinIsGpio |-> !wakeReq; endproperty
  a_off: assert property (p_off) else $error("pin off yet request");
  property p_fall; $fell(pinLevel) && !pinIsGpio && !mskQ && !wbRsp.ack
    |=> wakeReq; endproperty
  a_fall: assert property (p_fall) else $error("edge not latched");
  property p_clr; clr && !modeQ && !$fell(pinLevel) |=> !wakeReq; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_rst; $rose(rst_n) |-> !wakeReq && !irq && !wbRsp.ack;
  endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
  property p_msk; wakeReq && !wbRsp.ack |-> !mskQ; endproperty
  a_msk: assert property (p_msk) else $error("mask ignored");
  property p_glb; cpuIrqReq == (wakeReq && !cpuIntMask); endproperty
  a_glb: assert property (p_glb) else $error("global mask");
  property p_lvl; modeQ && !pinLevel && !pinIsGpio && !mskQ && !wbRsp.ack
    |-> wakeReq; endproperty
  a_lvl: assert property (p_lvl) else $error("low level dropped");
  property p_pin; $past(rst_n, 2) |-> pinLevel == $past(extIntPin_n, 2);
  endproperty
  a_pin: assert property (p_pin) else $error("pin level");
  property p_rd0; wbRsp.ack && wbReq.adr[7:2] == eipu_pkg::IDX_STATCTRL
    |-> !wbRsp.dat[eipu_pkg::BIT_ACK]; endproperty
  a_rd0: assert property (p_rd0) else $error("ack bit reads one");
endmodule // eipu_top_props

bind eipu_top eipu_top_props u_props (.clk, .rst_n, .wbReq, .wbRsp,
  .extIntPin_n, .vectorFetch, .cpuIntMask, .cpuIrqReq, .wakeReq,
  .pinLevel, .pinIsGpio, .irq);

// ---- dv/eipu_pin_src.sv ----
// interrupt source model: a pulled-up line that the source pulls low
// assumes pulse and hold change just after rising clock edges
`timescale 1ns/1ps
module eipu_pin_src (
  input  logic clk,    // clock
  input  logic pulse,  // start a three cycle low pulse
  input  logic hold,   // keep the line low
  output logic line_n  // line level, low while pulled down
);
  logic [1:0] cntQ = 2'h0;
  always @(posedge clk) begin
    if (pulse) begin
      cntQ <= 2'h3;
    end else if (cntQ != 2'h0) begin
      cntQ <= cntQ - 2'h1;
    end
  end
  // a released line goes high through the pull-up, never keeps a stale 0
  assign line_n = !(hold || cntQ != 2'h0);
endmodule // eipu_pin_src

// ---- dv/tb_top.sv ----
// self-checking bench of the external interrupt unit
// assumes eipu_top with its bound checker and the pin source model
`timescale 1ns/1ps
`define CHK(a, e) begin \
  checksDone++; \
  if ((a) !== (e)) begin \
    errorCnt++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, e); \
  end \
end
module tb_top;
  eipu_pkg::eipu_wb_req_t wbReq;
  eipu_pkg::eipu_wb_rsp_t wbRsp;
  logic clk, rst_n, extIntPin_n, vectorFetch, cpuIntMask, cpuIrqReq;
  logic wakeReq, pinLevel, pinIsGpio, irq, pulse, hold;
  int errorCnt, checksDone;
  eipu_top dut (.clk, .rst_n, .wbReq, .wbRsp, .extIntPin_n, .vectorFetch,
    .cpuIntMask, .cpuIrqReq, .wakeReq, .pinLevel, .pinIsGpio, .irq);
  eipu_pin_src src (.clk, .pulse, .hold, .line_n(extIntPin_n));
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [3:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wbReq <= {1'h1, 1'h1, w, 4'hF, a, 28'h000_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wbRsp.ack !== 1'h1 && n < 20);
    q = wbRsp.dat;
    if (n >= 20) begin
      errorCnt++;
      endOfTest();
    end
    wbReq <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    logic [31:0] q;
    wb(a, 1'h1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    logic [31:0] q;
    wb(a, 1'h0, 4'h0, q);
    `CHK(q, {28'h000_0000, e})
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic kick();
    pulse <= 1'h1;
    @(posedge clk);
    pulse <= 1'h0;
  endtask
  task automatic fetch();
    vectorFetch <= 1'h1;
    @(posedge clk);
    vectorFetch <= 1'h0;
  endtask
  task automatic endOfTest();
    $display("mismatches %0d checks %0d", errorCnt, checksDone);
    if (errorCnt == 0 && checksDone > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    cyc(3000);
    errorCnt++;
    endOfTest();
  end
  initial begin
    errorCnt = 0;
    checksDone = 0;
    rst_n = 1'h0;
    wbReq = '0;
    vectorFetch = 1'h0;
    cpuIntMask = 1'h0;
    pulse = 1'h0;
    hold = 1'h0;
    cyc(6);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(8'h00, 4'h0);
    rd(8'h04, 4'h0);
    `CHK(pinIsGpio, 1'h1)
    rd(8'h10, 4'h1);
    kick();
    cyc(8);
    rd(8'h00, 4'h0);
    wr(8'h04, 4'h1);
    wr(8'h0C, 4'h3);
    rd(8'h0C, 4'h3);
    `CHK(pinIsGpio, 1'h0)
    cpuIntMask <= 1'h1;
    kick();
    cyc(6);
    `CHK(wakeReq, 1'h1)
    `CHK(cpuIrqReq, 1'h0)
    `CHK(irq, 1'h1)
    rd(8'h00, 4'h1);
    cpuIntMask <= 1'h0;
    cyc(1);
    `CHK(cpuIrqReq, 1'h1)
    wr(8'h00, 4'h4);
    `CHK(cpuIrqReq, 1'h0)
    rd(8'h00, 4'h5);
    wr(8'h00, 4'h0);
    fetch();
    cyc(1);
    rd(8'h00, 4'h0);
    rd(8'h08, 4'h3);
    wr(8'h08, 4'h3);
    rd(8'h08, 4'h0);
    `CHK(irq, 1'h0)
    hold <= 1'h1;
    cyc(6);
    `CHK(pinLevel, 1'h0)
    rd(8'h10, 4'h0);
    wr(8'h00, 4'h2);
    rd(8'h00, 4'h0);
    hold <= 1'h0;
    cyc(2);
    kick();
    cyc(6);
    rd(8'h00, 4'h1);
    wr(8'h00, 4'h2);
    wr(8'h00, 4'h8);
    hold <= 1'h1;
    cyc(6);
    fetch();
    rd(8'h00, 4'h9);
    hold <= 1'h0;
    cyc(5);
    rd(8'h00, 4'h8);
    hold <= 1'h1;
    cyc(6);
    wr(8'h00, 4'hC);
    hold <= 1'h0;
    cyc(5);
    rd(8'h00, 4'hD);
    wr(8'h00, 4'hA);
    rd(8'h00, 4'h8);
    wr(8'h00, 4'h9);
    rd(8'h00, 4'h8);
    rd(8'h40, 4'h0);
    hold <= 1'h1;
    cyc(6);
    rst_n <= 1'h0;
    cyc(2);
    rst_n <= 1'h1;
    cyc(1);
    rd(8'h00, 4'h0);
    wr(8'h04, 4'h1);
    cyc(4);
    rd(8'h00, 4'h0);
    endOfTest();
  end
endmodule // tb_top
